/* File: hw/rf_cmd_device.sv */
// What this block does
// - Host asks register count before readback
// - Config id must be 00-1C or 80-9C
// - Multi-byte values travel low byte first
// - Code 15 has no parameters, does nothing
// - Field-on: bit0 no collision avoid, bit1 active
// - Field-on done flag when enabled
// - Field-off ignores its byte, field goes off
// - Field-off done flag when enabled
// - Route command: group byte, one to four pin bytes
// - Low nibble signal, high nibble pin
// - No debug output unless allow setting is set
// - All debug pins drive their signals together
// - Index 8 is carrier clock, 9-15 reserved
// - Pin 0 irq, 1 aux one, 2 aux two, 3 general
// - Group byte picks one of seven groups
// - Clock group index meanings
// - Timer group: running and expiry per timer
// - Card mode group index meanings
// - Transceive group index meanings
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rf_cmd_device (
	input wire logic mclk,
	input wire logic rst_b,
	rf_cmd_if.dev link,
	input wire logic debugAllow,
	input wire logic onFlagEnable,
	input wire logic offFlagEnable,
	input wire logic onFlagClear,
	input wire logic offFlagClear,
	input wire logic [7:0] clkSigs,
	input wire logic [7:0] txEncSigs,
	input wire logic [7:0] timerSigs,
	input wire logic [7:0] cardSigs,
	input wire logic [7:0] trxSigs,
	input wire logic carrier,
	output logic fieldActive,
	output logic noCollisionAvoid,
	output logic activeMode,
	output logic fieldOnDone,
	output logic fieldOffDone,
	output logic [3:0] debugPin
);
	rf_cmd_pkg::dev_state_t state;
	rf_cmd_pkg::dev_state_t next_state;
	logic [7:0] code;
	logic [7:0] cfgId;
	logic [2:0] paramIdx;
	logic [7:0] routeGroup;
	logic [7:0] pinGroup [rf_cmd_pkg::PIN_COUNT];
	logic [3:0] pinSel [rf_cmd_pkg::PIN_COUNT];
	logic [3:0] pinUsed;
	logic fieldPrev;
	logic [39:0] txShift;
	logic [7:0] bytesLeft;
	logic [2:0] byteInPair;
	logic [7:0] pairAddr;
	logic exc;

	wire logic take;
	wire logic inParam;
	wire logic firstParam;
	wire logic idOk;
	wire logic isQuery;
	wire logic routePinByte;
	wire logic [3:0] pinNib;
	wire logic [3:0] sigNib;
	wire logic fieldRise;
	wire logic fieldFall;
	wire logic [7:0] nextAddr;
	wire logic [7:0] readbackBytes;

	assign link.reqReady = (state != rf_cmd_pkg::ST_RESP);
	assign take = link.reqValid & link.reqReady;
	assign inParam = take & (state == rf_cmd_pkg::ST_PARAM);
	assign firstParam = inParam & (paramIdx == 3'h0);
	assign idOk = rf_cmd_pkg::id_in_range(link.reqByte);
	assign isQuery = (code == rf_cmd_pkg::CMD_SIZE_QUERY) || (code == rf_cmd_pkg::CMD_READBACK);
	assign pinNib = link.reqByte[7:4];
	assign sigNib = link.reqByte[3:0];
	// Pin bytes beyond the fourth or with reserved pin codes are dropped
	assign routePinByte = inParam & (code == rf_cmd_pkg::CMD_DEBUG_ROUTE) & (paramIdx != 3'h0) &
		(paramIdx <= rf_cmd_pkg::ROUTE_LAST_PARAM) & (pinNib <= rf_cmd_pkg::PIN_MAX);
	assign fieldRise = fieldActive & ~fieldPrev;
	assign fieldFall = ~fieldActive & fieldPrev;
	assign nextAddr = pairAddr + 8'h01;
	localparam int CFG_READBACK_BYTES = int'(rf_cmd_pkg::CFG_REG_COUNT) * int'(rf_cmd_pkg::PAIR_BYTES);
	assign readbackBytes = 8'(CFG_READBACK_BYTES);

	assign link.rspValid = (state == rf_cmd_pkg::ST_RESP);
	assign link.rspByte = txShift[7:0];
	assign link.rspLast = (state == rf_cmd_pkg::ST_RESP) && (bytesLeft == 8'h01);
	assign link.rspExc = exc;

	always_comb begin
		next_state = state;
		case (state)
			rf_cmd_pkg::ST_IDLE: begin
				if (take && !link.reqLast) begin
					next_state = rf_cmd_pkg::ST_PARAM;
				end
			end
			rf_cmd_pkg::ST_PARAM: begin
				if (take && link.reqLast) begin
					next_state = (isQuery && paramIdx == 3'h0 && idOk) ? rf_cmd_pkg::ST_RESP : rf_cmd_pkg::ST_IDLE;
				end
			end
			rf_cmd_pkg::ST_RESP: begin
				if (bytesLeft == 8'h01) begin
					next_state = rf_cmd_pkg::ST_IDLE;
				end
			end
			default: next_state = rf_cmd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= rf_cmd_pkg::ST_IDLE;
			code <= 8'h00;
			paramIdx <= 3'h0;
		end else begin
			state <= next_state;
			// A code with no parameter bytes, such as 15, never leaves idle
			if (take && state == rf_cmd_pkg::ST_IDLE) begin
				code <= link.reqByte;
			end
			if (take && state == rf_cmd_pkg::ST_IDLE) begin
				paramIdx <= 3'h0;
			end else if (inParam && paramIdx != 3'h7) begin
				paramIdx <= paramIdx + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfgId <= 8'h00;
			exc <= 1'b0;
		end else begin
			if (firstParam && isQuery) begin
				cfgId <= link.reqByte;
			end
			exc <= firstParam & isQuery & link.reqLast & ~idOk;
		end
	end

	// Response bytes: count for the size query, address then content low byte first for readback
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			txShift <= 40'h00_0000_0000;
			bytesLeft <= 8'h00;
			byteInPair <= 3'h0;
			pairAddr <= 8'h00;
		end else if (state == rf_cmd_pkg::ST_PARAM && next_state == rf_cmd_pkg::ST_RESP) begin
			byteInPair <= 3'h0;
			pairAddr <= 8'h00;
			if (code == rf_cmd_pkg::CMD_SIZE_QUERY) begin
				txShift <= {32'h0000_0000, rf_cmd_pkg::CFG_REG_COUNT};
				bytesLeft <= 8'h01;
			end else begin
				txShift <= {rf_cmd_pkg::cfg_content(link.reqByte, 8'h00), 8'h00};
				bytesLeft <= readbackBytes;
			end
		end else if (state == rf_cmd_pkg::ST_RESP) begin
			bytesLeft <= bytesLeft - 8'h01;
			if (byteInPair == rf_cmd_pkg::PAIR_LAST_BYTE) begin
				byteInPair <= 3'h0;
				pairAddr <= nextAddr;
				txShift <= {rf_cmd_pkg::cfg_content(cfgId, nextAddr), nextAddr};
			end else begin
				byteInPair <= byteInPair + 3'h1;
				txShift <= {8'h00, txShift[39:8]};
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fieldActive <= 1'b0;
			noCollisionAvoid <= 1'b0;
			activeMode <= 1'b0;
			fieldPrev <= 1'b0;
		end else begin
			fieldPrev <= fieldActive;
			if (firstParam && code == rf_cmd_pkg::CMD_FIELD_ON) begin
				fieldActive <= 1'b1;
				noCollisionAvoid <= link.reqByte[rf_cmd_pkg::FIELD_BIT_NO_CA];
				activeMode <= link.reqByte[rf_cmd_pkg::FIELD_BIT_ACTIVE];
			end else if (firstParam && code == rf_cmd_pkg::CMD_FIELD_OFF) begin
				fieldActive <= 1'b0;
			end
		end
	end

	// Set wins over a clear in the same cycle so no completion is lost
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fieldOnDone <= 1'b0;
			fieldOffDone <= 1'b0;
		end else begin
			fieldOnDone <= (fieldRise & onFlagEnable) | (fieldOnDone & ~onFlagClear);
			fieldOffDone <= (fieldFall & offFlagEnable) | (fieldOffDone & ~offFlagClear);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			routeGroup <= 8'h00;
			pinUsed <= 4'h0;
			for (int i = 0; i < rf_cmd_pkg::PIN_COUNT; i++) begin
				pinGroup[i] <= 8'h00;
				pinSel[i] <= 4'h0;
			end
		end else begin
			if (firstParam && code == rf_cmd_pkg::CMD_DEBUG_ROUTE) begin
				routeGroup <= link.reqByte;
			end
			if (routePinByte) begin
				pinGroup[pinNib[1:0]] <= routeGroup;
				pinSel[pinNib[1:0]] <= sigNib;
				pinUsed[pinNib[1:0]] <= 1'b1;
			end
		end
	end

	// One selector per pin so every pin carries its own signal at once
	for (genvar p = 0; p < rf_cmd_pkg::PIN_COUNT; p++) begin : gPin
		debug_pin_mux uMux (
			.mclk(mclk),
			.rst_b(rst_b),
			.group(pinGroup[p]),
			.sel(pinSel[p]),
			.used(pinUsed[p]),
			.allow(debugAllow),
			.clkSigs(clkSigs),
			.txEncSigs(txEncSigs),
			.timerSigs(timerSigs),
			.cardSigs(cardSigs),
			.trxSigs(trxSigs),
			.carrier(carrier),
			.pinOut(debugPin[p])
		);
	end
endmodule
`default_nettype wire

/* File: hw/rf_cmd_pkg.sv */
package rf_cmd_pkg;

	localparam logic [7:0] CMD_SIZE_QUERY = 8'h13;
	localparam logic [7:0] CMD_READBACK = 8'h14;
	localparam logic [7:0] CMD_RESERVED = 8'h15;
	localparam logic [7:0] CMD_FIELD_ON = 8'h16;
	localparam logic [7:0] CMD_FIELD_OFF = 8'h17;
	localparam logic [7:0] CMD_DEBUG_ROUTE = 8'h18;

	localparam logic [7:0] ID_LOW_MIN = 8'h00;
	localparam logic [7:0] ID_LOW_MAX = 8'h1C;
	localparam logic [7:0] ID_HIGH_MIN = 8'h80;
	localparam logic [7:0] ID_HIGH_MAX = 8'h9C;

	localparam int FIELD_BIT_NO_CA = 0;
	localparam int FIELD_BIT_ACTIVE = 1;

	// Every configuration reports the same register count
	localparam logic [7:0] CFG_REG_COUNT = 8'h04;
	localparam logic [2:0] PAIR_BYTES = 3'h5;
	localparam logic [2:0] PAIR_LAST_BYTE = 3'h4;

	localparam logic [7:0] GRP_CLOCK = 8'h01;
	localparam logic [7:0] GRP_TX_ENC = 8'h1B;
	localparam logic [7:0] GRP_TIMER = 8'h1D;
	localparam logic [7:0] GRP_CARD = 8'h30;
	localparam logic [7:0] GRP_TRANSCEIVE = 8'h58;
	localparam logic [7:0] GRP_RX_DATA = 8'h70;
	localparam logic [7:0] GRP_RX_ERROR = 8'h73;

	localparam int PIN_COUNT = 4;
	localparam logic [3:0] PIN_MAX = 4'h3;
	localparam logic [3:0] SIG_CARRIER = 4'h8;
	localparam logic [3:0] TX_ENC_LAST_IDX = 4'h1;
	localparam logic [3:0] TIMER_FIRST_IDX = 4'h2;
	localparam logic [2:0] ROUTE_LAST_PARAM = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PARAM = 3'b010,
		ST_RESP = 3'b100
	} dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_SEND = 3'b010,
		H_WAIT = 3'b100
	} host_state_t;

	function automatic logic id_in_range(input logic [7:0] id);
		id_in_range = (id >= ID_LOW_MIN && id <= ID_LOW_MAX) || (id >= ID_HIGH_MIN && id <= ID_HIGH_MAX);
	endfunction

	// Stand-in register contents while the update path is absent
	function automatic logic [31:0] cfg_content(input logic [7:0] id, input logic [7:0] addr);
		cfg_content = {id, addr, ~id, ~addr};
	endfunction

endpackage

/* File: hw/rf_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rf_cmd_if;
	logic reqValid;
	logic [7:0] reqByte;
	logic reqLast;
	logic reqReady;
	logic rspValid;
	logic [7:0] rspByte;
	logic rspLast;
	logic rspExc;

	modport dev (
		input reqValid,
		input reqByte,
		input reqLast,
		output reqReady,
		output rspValid,
		output rspByte,
		output rspLast,
		output rspExc
	);

	modport host (
		output reqValid,
		output reqByte,
		output reqLast,
		input reqReady,
		input rspValid,
		input rspByte,
		input rspLast,
		input rspExc
	);
endinterface
`default_nettype wire

/* File: hw/debug_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_pin_mux (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] group,
	input wire logic [3:0] sel,
	input wire logic used,
	input wire logic allow,
	input wire logic [7:0] clkSigs,
	input wire logic [7:0] txEncSigs,
	input wire logic [7:0] timerSigs,
	input wire logic [7:0] cardSigs,
	input wire logic [7:0] trxSigs,
	input wire logic carrier,
	output logic pinOut
);
	wire logic [7:0] groupVec;
	wire logic groupKnown;
	wire logic idxOk;
	wire logic picked;
	wire logic next_pinOut;

	assign groupVec = (group == rf_cmd_pkg::GRP_CLOCK) ? clkSigs :
		(group == rf_cmd_pkg::GRP_TX_ENC) ? txEncSigs :
		(group == rf_cmd_pkg::GRP_TIMER) ? timerSigs :
		(group == rf_cmd_pkg::GRP_CARD) ? cardSigs :
		(group == rf_cmd_pkg::GRP_TRANSCEIVE) ? trxSigs : 8'h00;
	// Receiver groups are decoded but their signals are not wired here
	assign groupKnown = (groupVec != 8'h00) || (group == rf_cmd_pkg::GRP_CLOCK) ||
		(group == rf_cmd_pkg::GRP_TX_ENC) || (group == rf_cmd_pkg::GRP_TIMER) || (group == rf_cmd_pkg::GRP_CARD) ||
		(group == rf_cmd_pkg::GRP_TRANSCEIVE) || (group == rf_cmd_pkg::GRP_RX_DATA) ||
		(group == rf_cmd_pkg::GRP_RX_ERROR);
	assign idxOk = !((group == rf_cmd_pkg::GRP_TX_ENC) && (sel > rf_cmd_pkg::TX_ENC_LAST_IDX)) &&
		!((group == rf_cmd_pkg::GRP_TIMER) && (sel < rf_cmd_pkg::TIMER_FIRST_IDX));
	assign picked = (sel == rf_cmd_pkg::SIG_CARRIER) ? carrier :
		(sel < rf_cmd_pkg::SIG_CARRIER) ? (groupVec[sel[2:0]] & idxOk) : 1'b0;
	assign next_pinOut = allow & used & groupKnown & picked;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pinOut <= 1'b0;
		end else begin
			pinOut <= next_pinOut;
		end
	end
endmodule
`default_nettype wire

/* File: hw/rf_cmd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rf_cmd_host (
	input wire logic mclk,
	input wire logic rst_b,
	rf_cmd_if.host link,
	input wire logic opStart,
	input wire logic [7:0] opCode,
	input wire logic [39:0] opParams,
	input wire logic [2:0] opLen,
	output logic opBusy,
	output logic idRejected,
	output logic countValid,
	output logic [7:0] countByte,
	output logic pairValid,
	output logic [7:0] pairAddr,
	output logic [31:0] pairData,
	output logic excSeen
);
	rf_cmd_pkg::host_state_t state;
	logic [47:0] txBuf;
	logic [2:0] txLeft;
	logic [7:0] sentCode;
	logic [7:0] cfgId;
	logic readbackPending;
	logic [2:0] rxPos;

	wire logic isQueryOp;
	wire logic idBad;
	wire logic accept;
	wire logic sent;
	wire logic lastSent;
	wire logic wantsReply;

	assign isQueryOp = (opCode == rf_cmd_pkg::CMD_SIZE_QUERY) || (opCode == rf_cmd_pkg::CMD_READBACK);
	assign idBad = isQueryOp & ~rf_cmd_pkg::id_in_range(opParams[7:0]);
	assign accept = opStart & (state == rf_cmd_pkg::H_IDLE);
	assign sent = (state == rf_cmd_pkg::H_SEND) & link.reqReady;
	assign lastSent = sent & (txLeft == 3'h1);
	assign wantsReply = (sentCode == rf_cmd_pkg::CMD_SIZE_QUERY) || (sentCode == rf_cmd_pkg::CMD_READBACK);

	assign link.reqValid = (state == rf_cmd_pkg::H_SEND);
	assign link.reqByte = txBuf[7:0];
	assign link.reqLast = (txLeft == 3'h1);
	assign opBusy = (state != rf_cmd_pkg::H_IDLE);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= rf_cmd_pkg::H_IDLE;
			txBuf <= 48'h0000_0000_0000;
			txLeft <= 3'h0;
			sentCode <= 8'h00;
			cfgId <= 8'h00;
			readbackPending <= 1'b0;
			rxPos <= 3'h0;
			idRejected <= 1'b0;
			countValid <= 1'b0;
			countByte <= 8'h00;
			pairValid <= 1'b0;
			pairAddr <= 8'h00;
			pairData <= 32'h0000_0000;
			excSeen <= 1'b0;
		end else begin
			idRejected <= accept & idBad;
			countValid <= 1'b0;
			pairValid <= 1'b0;
			excSeen <= link.rspExc;
			case (state)
				rf_cmd_pkg::H_IDLE: begin
					if (accept && !idBad) begin
						cfgId <= opParams[7:0];
						readbackPending <= (opCode == rf_cmd_pkg::CMD_READBACK);
						// Readback always starts with the size query
						sentCode <= (opCode == rf_cmd_pkg::CMD_READBACK) ? rf_cmd_pkg::CMD_SIZE_QUERY : opCode;
						txBuf <= {opParams, (opCode == rf_cmd_pkg::CMD_READBACK) ? rf_cmd_pkg::CMD_SIZE_QUERY : opCode};
						txLeft <= isQueryOp ? 3'h2 : opLen + 3'h1;
						state <= rf_cmd_pkg::H_SEND;
					end
				end
				rf_cmd_pkg::H_SEND: begin
					if (sent) begin
						txBuf <= {8'h00, txBuf[47:8]};
						txLeft <= txLeft - 3'h1;
						rxPos <= 3'h0;
					end
					if (lastSent) begin
						state <= wantsReply ? rf_cmd_pkg::H_WAIT : rf_cmd_pkg::H_IDLE;
					end
				end
				rf_cmd_pkg::H_WAIT: begin
					if (link.rspExc) begin
						state <= rf_cmd_pkg::H_IDLE;
					end else if (link.rspValid && sentCode == rf_cmd_pkg::CMD_SIZE_QUERY) begin
						countValid <= 1'b1;
						countByte <= link.rspByte;
						if (readbackPending && link.rspByte != 8'h00) begin
							readbackPending <= 1'b0;
							sentCode <= rf_cmd_pkg::CMD_READBACK;
							txBuf <= {32'h0000_0000, cfgId, rf_cmd_pkg::CMD_READBACK};
							txLeft <= 3'h2;
							state <= rf_cmd_pkg::H_SEND;
						end else begin
							state <= rf_cmd_pkg::H_IDLE;
						end
					end else if (link.rspValid) begin
						if (rxPos == 3'h0) begin
							pairAddr <= link.rspByte;
						end else begin
							pairData <= {link.rspByte, pairData[31:8]};
						end
						pairValid <= (rxPos == rf_cmd_pkg::PAIR_LAST_BYTE);
						rxPos <= (rxPos == rf_cmd_pkg::PAIR_LAST_BYTE) ? 3'h0 : rxPos + 3'h1;
						if (link.rspLast) begin
							state <= rf_cmd_pkg::H_IDLE;
						end
					end
				end
				default: state <= rf_cmd_pkg::H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: test/rf_cmd_props.sv */
`timescale 1ns/1ps
`default_nettype none
module rf_cmd_props (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic reqValid,
	input wire logic [7:0] reqByte,
	input wire logic reqLast,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic [7:0] rspByte,
	input wire logic rspLast,
	input wire logic rspExc
);
	logic [4:0] rspCnt;
	wire take = reqValid && reqReady;
	wire idOk = (reqByte <= 8'h1C) || (reqByte >= 8'h80 && reqByte <= 8'h9C);
	wire lastTake = take && reqLast;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) rspCnt <= 5'h00;
		else rspCnt <= rspValid ? rspCnt + 5'h01 : 5'h00;
	end
	// Tracks whether a route command is open on the link
	logic midCmd;
	logic routeCmd;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			midCmd <= 1'b0;
			routeCmd <= 1'b0;
		end else if (take) begin
			midCmd <= !reqLast;
			if (!midCmd) routeCmd <= (reqByte == 8'h18);
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_readback_bytes;
		(take && !reqLast && reqByte == 8'h14) ##1 (lastTake && idOk) |=> rspValid && rspByte == 8'h00
			##1 rspByte == 8'hFF ##1 rspByte == ~$past(reqByte, 3) ##1 rspByte == 8'h00 ##1 rspByte == $past(reqByte, 5);
	endproperty
	a_readback_bytes: assert property (p_readback_bytes) else $error("readback bytes wrong");
	property p_size_reply;
		(take && !reqLast && reqByte == 8'h13) ##1 (lastTake && idOk) |=> rspValid && rspLast && rspByte == 8'h04;
	endproperty
	a_size_reply: assert property (p_size_reply) else $error("size reply wrong");
	property p_bad_id;
		(take && !reqLast && (reqByte == 8'h13 || reqByte == 8'h14)) ##1 (lastTake && !idOk) |=> rspExc && !rspValid;
	endproperty
	a_bad_id: assert property (p_bad_id) else $error("bad id not flagged");
	property p_exc_pulse;
		rspExc |=> !rspExc;
	endproperty
	a_exc_pulse: assert property (p_exc_pulse) else $error("exception longer than one cycle");
	property p_rsp_length;
		rspLast |-> rspValid && (rspCnt == 5'h00 || rspCnt == 5'h13);
	endproperty
	a_rsp_length: assert property (p_rsp_length) else $error("response length wrong");
	property p_reserved_quiet;
		(take && reqLast && reqByte == 8'h15) |=> !rspValid && !rspExc ##1 !rspValid && !rspExc;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code answered");
	property p_field_quiet;
		(take && !reqLast && (reqByte == 8'h16 || reqByte == 8'h17)) ##1 lastTake |=> !rspValid [*3];
	endproperty
	a_field_quiet: assert property (p_field_quiet) else $error("field command answered");
	property p_route_quiet;
		(routeCmd && (midCmd || $past(take && reqLast))) |-> !rspValid && !rspExc;
	endproperty
	a_route_quiet: assert property (p_route_quiet) else $error("route command answered");
	property p_no_take_in_rsp;
		rspValid |-> !reqReady;
	endproperty
	a_no_take_in_rsp: assert property (p_no_take_in_rsp) else $error("ready during response");
endmodule
`default_nettype wire

/* File: test/rf_field_and_debug_bus_cmds_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rf_field_and_debug_bus_cmds_tb_top;
	logic mclk = 1'b0, rst_b = 1'b0, opStart = 1'b0;
	logic [7:0] opCode = 8'h00, clkSigs = 8'h80, txEncSigs = 8'h06, timerSigs = 8'h82, cardSigs = 8'h40, trxSigs = 8'h06;
	logic [39:0] opParams = 40'h0;
	logic [2:0] opLen = 3'h0;
	logic debugAllow = 1'b0, onFlagEnable = 1'b0, offFlagEnable = 1'b0, onFlagClear = 1'b0, offFlagClear = 1'b0;
	logic carrier = 1'b1;
	logic opBusy, idRejected, countValid, pairValid, excSeen, fieldActive, noCollisionAvoid, activeMode;
	logic fieldOnDone, fieldOffDone;
	logic [7:0] countByte, pairAddr;
	logic [31:0] pairData;
	logic [3:0] debugPin;
	logic [7:0] pAddr [4];
	logic [31:0] pData [4];
	int pairCnt = 0, rejCnt = 0, excCnt = 0, err_count = 0, n_tests = 0, cycles = 0;
	rf_cmd_if link ();
	rf_cmd_device u_rf_cmd_device (.mclk(mclk), .rst_b(rst_b), .link(link.dev), .debugAllow(debugAllow),
		.onFlagEnable(onFlagEnable), .offFlagEnable(offFlagEnable), .onFlagClear(onFlagClear),
		.offFlagClear(offFlagClear), .clkSigs(clkSigs), .txEncSigs(txEncSigs), .timerSigs(timerSigs),
		.cardSigs(cardSigs), .trxSigs(trxSigs), .carrier(carrier), .fieldActive(fieldActive),
		.noCollisionAvoid(noCollisionAvoid), .activeMode(activeMode), .fieldOnDone(fieldOnDone),
		.fieldOffDone(fieldOffDone), .debugPin(debugPin));
	rf_cmd_host u_rf_cmd_host (.mclk(mclk), .rst_b(rst_b), .link(link.host), .opStart(opStart), .opCode(opCode),
		.opParams(opParams), .opLen(opLen), .opBusy(opBusy), .idRejected(idRejected), .countValid(countValid),
		.countByte(countByte), .pairValid(pairValid), .pairAddr(pairAddr), .pairData(pairData), .excSeen(excSeen));
	rf_cmd_props u_rf_cmd_props (.mclk(mclk), .rst_b(rst_b), .reqValid(link.reqValid), .reqByte(link.reqByte),
		.reqLast(link.reqLast), .reqReady(link.reqReady), .rspValid(link.rspValid), .rspByte(link.rspByte),
		.rspLast(link.rspLast), .rspExc(link.rspExc));
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (pairValid === 1'b1 && pairCnt < 4) begin
			pAddr[pairCnt] <= pairAddr;
			pData[pairCnt] <= pairData;
		end
		if (pairValid === 1'b1) pairCnt <= pairCnt + 1;
		if (idRejected === 1'b1) rejCnt <= rejCnt + 1;
		if (excSeen === 1'b1) excCnt <= excCnt + 1;
		cycles <= cycles + 1;
		// Whole run is well under this; a hang lands in the report
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic run_op(input logic [7:0] c, input logic [39:0] p, input logic [2:0] n);
		int k;
		k = 0;
		opCode <= c;
		opParams <= p;
		opLen <= n;
		opStart <= 1'b1;
		@(posedge mclk);
		opStart <= 1'b0;
		@(negedge mclk);
		while (opBusy !== 1'b0 && k < 300) begin
			@(negedge mclk);
			k++;
		end
		chk("op finished", k < 300, 1'b1);
		repeat (3) @(posedge mclk);
	endtask
	task automatic test_readback();
		logic [7:0] ids [2];
		ids = '{8'h1C, 8'h80};
		foreach (ids[i]) begin
			pairCnt = 0;
			run_op(8'h14, {32'h0, ids[i]}, 3'h1);
			chk("count", countByte, 8'h04);
			chk("pairs", pairCnt, 4);
			for (int k = 0; k < 4; k++) begin
				chk("addr", pAddr[k], k);
				chk("content", pData[k], {ids[i], 8'(k), ~ids[i], ~8'(k)});
			end
		end
		$display("readback done");
	endtask
	task automatic test_bad_id();
		logic [7:0] ids [2];
		ids = '{8'h1D, 8'h9D};
		foreach (ids[i]) begin
			pairCnt = 0;
			rejCnt = 0;
			run_op(8'h14, {32'h0, ids[i]}, 3'h1);
			chk("rejected", rejCnt, 1);
			chk("no pairs", pairCnt, 0);
		end
		chk("no exception", excCnt, 0);
		$display("bad id done");
	endtask
	task automatic test_field();
		onFlagEnable <= 1'b1;
		offFlagEnable <= 1'b1;
		run_op(8'h16, 40'h03, 3'h1);
		chk("field on", {fieldActive, noCollisionAvoid, activeMode, fieldOnDone}, 4'hF);
		run_op(8'h15, 40'h0, 3'h0);
		chk("reserved idle", {fieldActive, fieldOffDone}, 2'h2);
		onFlagClear <= 1'b1;
		@(posedge mclk);
		onFlagClear <= 1'b0;
		run_op(8'h17, 40'h5A, 3'h1);
		chk("field off", {fieldActive, fieldOnDone, fieldOffDone}, 3'h1);
		offFlagClear <= 1'b1;
		onFlagEnable <= 1'b0;
		@(posedge mclk);
		offFlagClear <= 1'b0;
		run_op(8'h16, 40'h02, 3'h1);
		chk("on unflagged", {fieldActive, noCollisionAvoid, activeMode, fieldOnDone}, 4'hA);
		$display("field done");
	endtask
	task automatic test_route();
		logic [23:0] tbl [12];
		tbl = '{24'h010801, 24'h010701, 24'h1B0101, 24'h1B0200, 24'h1D0701, 24'h1D0100, 24'h300601,
			24'h580201, 24'h580900, 24'h730801, 24'h700100, 24'h220800};
		debugAllow <= 1'b1;
		foreach (tbl[i]) begin
			run_op(8'h18, {24'h0, tbl[i][15:8], tbl[i][23:16]}, 3'h2);
			chk("pin0 signal", debugPin[0], tbl[i][0]);
		end
		run_op(8'h18, 40'h3827170701, 3'h5);
		chk("all pins", debugPin, 4'hF);
		clkSigs <= 8'h00;
		carrier <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("pins follow", debugPin, 4'h0);
		clkSigs <= 8'h80;
		carrier <= 1'b1;
		debugAllow <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("allow off", debugPin, 4'h0);
		$display("route done");
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		test_readback();
		test_bad_id();
		test_field();
		test_route();
		end_of_test();
	end
endmodule
`default_nettype wire
